/* File: hdl/hdt_pkg.sv */
// Shared constants and types for the holdover DAC tracking control block.
// Assumes a single clock domain and AXI4-Lite register access.
package hdt_pkg;

  // ==========================================================
  // Bus and register map (byte address = four times the index)
  localparam int         AXI_AW        = 12;
  localparam int         AXI_DW        = 32;
  localparam int         IDX_W         = 10;
  localparam logic [9:0] IDX_HOLD_CTRL = 10'h14B;
  localparam logic [9:0] IDX_MAN_LO    = 10'h14C;
  localparam logic [9:0] IDX_TRIP_LO   = 10'h14D;
  localparam logic [9:0] IDX_RATE_TRIP = 10'h14E;
  localparam logic [9:0] IDX_RATE_CNT  = 10'h14F;
  localparam logic [9:0] IDX_RAIL_CTRL = 10'h170;
  localparam logic [9:0] IDX_STATUS    = 10'h171;
  localparam logic [9:0] IDX_IRQ_STAT  = 10'h172;
  localparam logic [9:0] IDX_IRQ_MASK  = 10'h173;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ==========================================================
  // Field positions
  localparam int TRACK_EN_BIT = 4;
  localparam int FORCE_BIT    = 3;
  localparam int MAN_SEL_BIT  = 2;
  localparam int MULT_LSB     = 6;
  localparam int STAT_RUN_BIT = 10;
  localparam int STAT_HOLD_BIT = 11;
  localparam int IRQ_LOW      = 0;
  localparam int IRQ_HIGH     = 1;
  localparam int IRQ_N        = 2;

  // ==========================================================
  // Reset values and scaling
  localparam logic [1:0]  MAN_HI_RST   = 2'h2;
  localparam logic [7:0]  MAN_LO_RST   = 8'h00;
  localparam logic [5:0]  TRIP_RST     = 6'h00;
  localparam logic [1:0]  MULT_RST     = 2'h0;
  localparam logic [7:0]  COUNT_RST    = 8'h7F;
  localparam logic        TRACK_EN_RST = 1'b1;
  localparam logic        MAN_SEL_RST  = 1'b1;
  localparam logic        FORCE_RST    = 1'b0;
  localparam logic        RAIL_EN_RST  = 1'b0;
  localparam logic [1:0]  IRQ_RST      = 2'h0;
  localparam logic [9:0]  TRACK_START  = 10'h200;
  localparam logic [9:0]  DAC_MAX      = 10'h3FF;
  localparam logic [10:0] FULL_SCALE   = 11'h400;
  localparam int          LVL_SH       = 4;
  localparam logic [4:0]  MULT_BASE_SH = 5'h02;
  localparam logic [4:0]  MULT_STEP_SH = 5'h04;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       en;
    logic [9:0] idx;
    logic [7:0] data;
  } hdt_wr_t;

  typedef struct packed {
    logic       en;
    logic [9:0] idx;
  } hdt_rd_t;

  typedef enum {TRK_PAUSED, TRK_RUN, TRK_FROZEN} hdt_trk_t;

endpackage

/* File: hdl/hdt_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read in flight at most.
// Assumes the parent decodes the index and returns read data in-cycle.
`timescale 1ns/1ps
`default_nettype none
module hdt_axil_slave
  import hdt_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // AXI4-Lite
  input  wire logic [AXI_AW-1:0] awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [AXI_DW-1:0] wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  input  wire logic [AXI_AW-1:0] araddr_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [AXI_DW-1:0]      rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  // Register side
  output hdt_wr_t                wr_o,
  input  wire logic              wok_i,
  output hdt_rd_t                rd_o,
  input  wire logic [AXI_DW-1:0] rdata_i,
  input  wire logic              rok_i
);

  logic [AXI_AW-1:0] awaddr_q;
  logic [7:0]        wdata_q;
  logic              wlane_q;
  logic              fire;

  // Both halves held and no response pending
  assign fire = !awready_o && !wready_o && !bvalid_o;
  assign wr_o.en   = fire && wlane_q && (awaddr_q[1:0] == 2'h0);
  assign wr_o.idx  = awaddr_q[AXI_AW-1:2];
  assign wr_o.data = wdata_q;
  assign rd_o.en   = arvalid_i && arready_o;
  assign rd_o.idx  = araddr_i[AXI_AW-1:2];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      awready_o <= 1'b1;
      wready_o  <= 1'b1;
      bvalid_o  <= 1'b0;
      bresp_o   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wlane_q   <= 1'b0;
    end
    else
    begin
      if (awvalid_i && awready_o)
      begin
        awready_o <= 1'b0;
        awaddr_q  <= awaddr_i;
      end
      if (wvalid_i && wready_o)
      begin
        wready_o <= 1'b0;
        wdata_q  <= wdata_i[7:0];
        wlane_q  <= wstrb_i[0];
      end
      if (fire)
      begin
        bvalid_o <= 1'b1;
        bresp_o  <= (wok_i && awaddr_q[1:0] == 2'h0) ? RESP_OKAY
                                                     : RESP_SLVERR;
      end
      if (bvalid_o && bready_i)
      begin
        bvalid_o  <= 1'b0;
        awready_o <= 1'b1;
        wready_o  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= '0;
      rresp_o   <= RESP_OKAY;
    end
    else if (rd_o.en)
    begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b1;
      rdata_o   <= rdata_i;
      rresp_o   <= (rok_i && araddr_i[1:0] == 2'h0) ? RESP_OKAY
                                                    : RESP_SLVERR;
    end
    else if (rvalid_o && rready_i)
    begin
      rvalid_o  <= 1'b0;
      arready_o <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/hdt_rate_timer.sv */
// Tracking update timer: counts phase-detector ticks up to mult * count.
// Assumes tick_i is a one-cycle enable at the phase-detector rate.
`timescale 1ns/1ps
`default_nettype none
module hdt_rate_timer
  import hdt_pkg::*;
#(
  parameter int PER_W = 22
)
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Rate setting and tick
  input  wire logic       tick_i,
  input  wire logic [1:0] mult_i,
  input  wire logic [7:0] count_i,
  output logic            upd_o
);

  logic [PER_W-1:0] cnt_q;
  logic [PER_W-1:0] period;
  logic [4:0]       sh;

  // Multiplier is 4 << (4 * code), so the product is a shift
  always_comb
  begin
    sh     = MULT_BASE_SH + 5'(mult_i) * MULT_STEP_SH;
    period = PER_W'(count_i) << sh;
  end

  // Zero count means no updates; >= absorbs a shortened period
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      upd_o <= 1'b0;
    end
    else
    begin
      upd_o <= 1'b0;
      if (tick_i && period != '0)
      begin
        if (cnt_q >= period - PER_W'(1))
        begin
          cnt_q <= '0;
          upd_o <= 1'b1;
        end
        else
          cnt_q <= cnt_q + PER_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

/* File: hdl/hdt_top.sv */
// Holdover DAC tracking control: registers, tracking, rail trips, IRQ.
// Assumes PD_TICK_I pulses once per phase-detector period of the first
// loop, and TUNE_CODE_I is the tuning voltage as a 10-bit DAC code.
//
// Overview of operation
// R1: Manual value is ten bits, upper two then lower eight; resets 2 and 0.
// R2: Manual select drives the DAC with the manual value, 0 to 1023.
// R3: Six-bit lower trip at (code+1)/64 of supply above ground; default 0.
// R4: Six-bit upper trip at (code+1)/64 below supply; default 0.
// R5: Two-bit multiplier in bits 7:6 picks 4, 64, 1024, 16384; default 0.
// R6: Eight-bit rate count, 0 to 255, default 127, sets update rate.
// R7: Tracked value updates once per multiplier times count PD cycles.
// R8: Enabled rail detect at a trip marks input invalid, raises switch.
// R9: Forced holdover uses manual value if selected, else last tracked.
// R10: Tracking enabled by default, runs only while locked, starts at 512.
// R11: Tracked value saturates at 0 and 1023 and holds when paused.
`timescale 1ns/1ps
`default_nettype none
module hdt_top
  import hdt_pkg::*;
#(
  parameter int PER_W = 22
)
(
  // Clock and reset
  input  wire logic              CLK_I,
  input  wire logic              SYS_RST_I,
  // AXI4-Lite write
  input  wire logic [AXI_AW-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [AXI_DW-1:0] S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  // AXI4-Lite read
  input  wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [AXI_DW-1:0]      S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  // First loop status
  input  wire logic              PD_TICK_I,
  input  wire logic              FIRST_LOOP_LOCKED_I,
  input  wire logic [9:0]        TUNE_CODE_I,
  // DAC and holdover
  output logic [9:0]             DAC_CODE_O,
  output logic                   HOLDOVER_O,
  output logic                   CLK_SWITCH_O,
  output logic                   IRQ_O
);

  // ==========================================================
  // Declarations
  hdt_wr_t            wr;
  hdt_rd_t            rd;
  logic [AXI_DW-1:0]  rdata;
  logic               rok;
  logic               wok;
  logic               track_en_q;
  logic               force_q;
  logic               man_sel_q;
  logic [1:0]         man_hi_q;
  logic [7:0]         man_lo_q;
  logic [5:0]         trip_lo_q;
  logic [1:0]         mult_q;
  logic [5:0]         trip_hi_q;
  logic [7:0]         count_q;
  logic               rail_en_q;
  logic [IRQ_N-1:0]   irq_st_q;
  logic [IRQ_N-1:0]   irq_mask_q;
  logic [IRQ_N-1:0]   evt;
  logic [9:0]         tracked_q;
  logic [9:0]         tracked_d;
  logic [9:0]         man_value;
  hdt_trk_t           trk_q;
  hdt_trk_t           trk_d;
  logic               upd;
  logic [10:0]        lo_lvl;
  logic [10:0]        hi_lvl;
  logic               low_trip;
  logic               high_trip;
  logic               low_trip_q;
  logic               high_trip_q;

  assign man_value = {man_hi_q, man_lo_q}; // R1

  // ==========================================================
  // Bus front end
  hdt_axil_slave u_bus (
    .clk_i     (CLK_I),
    .rst_i     (SYS_RST_I),
    .awaddr_i  (S_AXI_AWADDR_I),
    .awvalid_i (S_AXI_AWVALID_I),
    .awready_o (S_AXI_AWREADY_O),
    .wdata_i   (S_AXI_WDATA_I),
    .wstrb_i   (S_AXI_WSTRB_I),
    .wvalid_i  (S_AXI_WVALID_I),
    .wready_o  (S_AXI_WREADY_O),
    .bresp_o   (S_AXI_BRESP_O),
    .bvalid_o  (S_AXI_BVALID_O),
    .bready_i  (S_AXI_BREADY_I),
    .araddr_i  (S_AXI_ARADDR_I),
    .arvalid_i (S_AXI_ARVALID_I),
    .arready_o (S_AXI_ARREADY_O),
    .rdata_o   (S_AXI_RDATA_O),
    .rresp_o   (S_AXI_RRESP_O),
    .rvalid_o  (S_AXI_RVALID_O),
    .rready_i  (S_AXI_RREADY_I),
    .wr_o      (wr),
    .wok_i     (wok),
    .rd_o      (rd),
    .rdata_i   (rdata),
    .rok_i     (rok)
  );

  // Status register is read-only, so writing it is refused
  assign wok = (wr.idx inside {IDX_HOLD_CTRL, IDX_MAN_LO, IDX_TRIP_LO,
                               IDX_RATE_TRIP, IDX_RATE_CNT, IDX_RAIL_CTRL,
                               IDX_IRQ_STAT, IDX_IRQ_MASK});

  // ==========================================================
  // Read mux
  always_comb
  begin
    rdata = '0;
    rok   = 1'b1;
    unique case (rd.idx)
      IDX_HOLD_CTRL:
      begin
        rdata[TRACK_EN_BIT] = track_en_q;
        rdata[FORCE_BIT]    = force_q;
        rdata[MAN_SEL_BIT]  = man_sel_q;
        rdata[1:0]          = man_hi_q;
      end
      IDX_MAN_LO:    rdata[7:0] = man_lo_q;
      IDX_TRIP_LO:   rdata[5:0] = trip_lo_q;
      IDX_RATE_TRIP: rdata[7:0] = {mult_q, trip_hi_q};
      IDX_RATE_CNT:  rdata[7:0] = count_q;
      IDX_RAIL_CTRL: rdata[0]   = rail_en_q;
      IDX_STATUS:
      begin
        rdata[9:0]           = tracked_q;
        rdata[STAT_RUN_BIT]  = (trk_q == TRK_RUN);
        rdata[STAT_HOLD_BIT] = HOLDOVER_O;
      end
      IDX_IRQ_STAT:  rdata[IRQ_N-1:0] = irq_st_q;
      IDX_IRQ_MASK:  rdata[IRQ_N-1:0] = irq_mask_q;
      default:       rok = 1'b0;
    endcase
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      track_en_q <= TRACK_EN_RST; // R10
      force_q    <= FORCE_RST; // R9
      man_sel_q  <= MAN_SEL_RST; // R9
      man_hi_q   <= MAN_HI_RST; // R1
      man_lo_q   <= MAN_LO_RST; // R1
      trip_lo_q  <= TRIP_RST; // R3
      mult_q     <= MULT_RST; // R5
      trip_hi_q  <= TRIP_RST; // R4
      count_q    <= COUNT_RST; // R6
      rail_en_q  <= RAIL_EN_RST;
      irq_mask_q <= IRQ_RST;
    end
    else if (wr.en)
    begin
      unique case (wr.idx)
        IDX_HOLD_CTRL:
        begin
          track_en_q <= wr.data[TRACK_EN_BIT];
          force_q    <= wr.data[FORCE_BIT];
          man_sel_q  <= wr.data[MAN_SEL_BIT];
          man_hi_q   <= wr.data[1:0]; // R1
        end
        IDX_MAN_LO:    man_lo_q <= wr.data; // R1
        IDX_TRIP_LO:   trip_lo_q <= wr.data[5:0]; // R3
        IDX_RATE_TRIP:
        begin
          mult_q    <= wr.data[MULT_LSB +: 2]; // R5
          trip_hi_q <= wr.data[5:0]; // R4
        end
        IDX_RATE_CNT:  count_q <= wr.data; // R6
        IDX_RAIL_CTRL: rail_en_q <= wr.data[0];
        IDX_IRQ_MASK:  irq_mask_q <= wr.data[IRQ_N-1:0];
        default:       ;
      endcase
    end
  end

  // ==========================================================
  // Update timer
  hdt_rate_timer #(
    .PER_W (PER_W)
  ) u_timer (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .tick_i  (PD_TICK_I),
    .mult_i  (mult_q),
    .count_i (count_q),
    .upd_o   (upd)
  );

  // ==========================================================
  // Tracking
  always_comb
  begin
    if (!track_en_q || !FIRST_LOOP_LOCKED_I)
      trk_d = TRK_PAUSED; // R10
    else if (force_q)
      trk_d = TRK_FROZEN; // R9
    else
      trk_d = TRK_RUN;
  end

  // One code per update keeps the DAC steps small; saturating ends
  always_comb
  begin
    tracked_d = tracked_q;
    unique case (trk_q)
      TRK_RUN:
      begin
        if (upd && TUNE_CODE_I > tracked_q && tracked_q != DAC_MAX)
          tracked_d = tracked_q + 10'h001; // R7 R11
        else if (upd && TUNE_CODE_I < tracked_q && tracked_q != '0)
          tracked_d = tracked_q - 10'h001; // R7 R11
      end
      TRK_PAUSED: tracked_d = tracked_q; // R11
      TRK_FROZEN: tracked_d = tracked_q; // R9
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      trk_q     <= TRK_PAUSED;
      tracked_q <= TRACK_START; // R10
    end
    else
    begin
      trk_q     <= trk_d;
      tracked_q <= tracked_d;
    end
  end

  // ==========================================================
  // Rail trips
  always_comb
  begin
    lo_lvl    = ({5'h00, trip_lo_q} + 11'h001) << LVL_SH; // R3
    hi_lvl    = FULL_SCALE - (({5'h00, trip_hi_q} + 11'h001) << LVL_SH); // R4
    low_trip  = {1'b0, tracked_q} <= lo_lvl; // R3
    high_trip = {1'b0, tracked_q} >= hi_lvl; // R4
    evt[IRQ_LOW]  = rail_en_q && low_trip && !low_trip_q; // R8
    evt[IRQ_HIGH] = rail_en_q && high_trip && !high_trip_q; // R8
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      low_trip_q   <= 1'b0;
      high_trip_q  <= 1'b0;
      DAC_CODE_O   <= TRACK_START;
      HOLDOVER_O   <= 1'b0;
      CLK_SWITCH_O <= 1'b0;
    end
    else
    begin
      low_trip_q   <= low_trip;
      high_trip_q  <= high_trip;
      DAC_CODE_O   <= man_sel_q ? man_value : tracked_q; // R2 R9
      HOLDOVER_O   <= force_q || (rail_en_q && (low_trip || high_trip));
      CLK_SWITCH_O <= |evt; // R8
    end
  end

  // ==========================================================
  // Interrupts
  // Set wins over a same-cycle write-one-to-clear
  for (genvar i = 0; i < IRQ_N; i++)
  begin : g_irq
    always_ff @(posedge CLK_I)
    begin
      if (SYS_RST_I)
        irq_st_q[i] <= 1'b0;
      else if (evt[i])
        irq_st_q[i] <= 1'b1;
      else if (wr.en && wr.idx == IDX_IRQ_STAT && wr.data[i])
        irq_st_q[i] <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(irq_st_q & irq_mask_q);
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_low_rise;
    !low_trip ##1 (low_trip && rail_en_q);
  endsequence

  sequence s_high_rise;
    !high_trip ##1 (high_trip && rail_en_q);
  endsequence

  sequence s_run_up;
    trk_q == TRK_RUN && upd && TUNE_CODE_I > tracked_q
      && tracked_q != DAC_MAX;
  endsequence

  a_reset_values: assert property ( // R1
    $fell(SYS_RST_I) |-> man_hi_q == MAN_HI_RST && man_lo_q == MAN_LO_RST
      && count_q == COUNT_RST && tracked_q == TRACK_START && man_sel_q)
    else $error("Register reset values wrong");

  a_manual_drive: assert property ( // R2
    man_sel_q |=> DAC_CODE_O == $past(man_value))
    else $error("Manual value not on DAC");

  a_force_tracked: assert property ( // R9
    (force_q && !man_sel_q) [*2] |=> DAC_CODE_O == $past(tracked_q)
      && $stable(tracked_q))
    else $error("Forced holdover did not hold tracked value");

  a_low_trip_evt: assert property ( // R3
    s_low_rise |=> CLK_SWITCH_O ##1 irq_st_q[IRQ_LOW])
    else $error("Lower trip gave no switch event");

  a_high_trip_evt: assert property ( // R4
    s_high_rise |=> CLK_SWITCH_O ##1 irq_st_q[IRQ_HIGH])
    else $error("Upper trip gave no switch event");

  a_rail_disabled: assert property ( // R8
    !rail_en_q |=> !CLK_SWITCH_O)
    else $error("Switch event while rail detect off");

  a_track_step: assert property ( // R7
    s_run_up |=> tracked_q == $past(tracked_q) + 10'h001)
    else $error("Tracked value did not step up");

  a_track_paused: assert property ( // R10
    !FIRST_LOOP_LOCKED_I ##1 trk_q == TRK_PAUSED |=> $stable(tracked_q))
    else $error("Tracking moved while unlocked");

  a_no_wrap: assert property ( // R11
    tracked_q == DAC_MAX |=> tracked_q != 10'h000)
    else $error("Tracked value wrapped");

  a_irq_level: assert property (
    ##1 IRQ_O == $past(|(irq_st_q & irq_mask_q)))
    else $error("Interrupt output mismatch");

  a_rate_zero: assert property ( // R6
    count_q == 8'h00 [*2] |-> !upd)
    else $error("Update with zero rate count");

  a_mult_field: assert property ( // R5
    wr.en && wr.idx == IDX_RATE_TRIP |=> mult_q == $past(wr.data[7:6]))
    else $error("Multiplier field not stored");

endmodule
`default_nettype wire

/* File: testbench/hdt_top_bench.sv */
// Self-checking bench for the holdover DAC tracking control block.
// Assumes hdt_pkg and the hdl/ sources are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none
module hdt_top_bench;
  import hdt_pkg::*;

  // ==========================================================
  // Stimulus and observed signals
  logic        clk, rst, awv, wv, bry, arv, rry, tick, lock, gap2;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, seed, r;
  logic [9:0]  tune, dac, sw_dac, v, d;
  logic [7:0]  mlo, c;
  logic [5:0]  lo, hi;
  logic [1:0]  br, rr;
  logic        awr, wrd, bv, arr, rv, sw, hold, irq;
  int          error_cnt, checks_done, nsw;

  hdt_top u_hdt_top (
    .CLK_I(clk), .SYS_RST_I(rst),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .PD_TICK_I(tick),
    .FIRST_LOOP_LOCKED_I(lock), .TUNE_CODE_I(tune), .DAC_CODE_O(dac),
    .HOLDOVER_O(hold), .CLK_SWITCH_O(sw), .IRQ_O(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Phase-detector tick: every other cycle, or every cycle for long periods
  always @(posedge clk) tick <= gap2 ? ~tick : 1'b1;

  always @(posedge clk)
    if (sw === 1'b1)
    begin
      nsw <= nsw + 1;
      sw_dac <= dac;
    end

  // ==========================================================
  // Expectations and helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int per_of(int m, int cn, int g);
    return (cn << (2 + 4 * m)) * g;
  endfunction

  function automatic logic [9:0] lo_lvl(logic [5:0] cd);
    return 10'((cd + 1) * 16);
  endfunction

  function automatic logic [9:0] hi_lvl(logic [5:0] cd);
    return 10'(1024 - (cd + 1) * 16);
  endfunction

  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] dt,
                    input logic [1:0] er);
    @(posedge clk);
    awa <= {i, 2'h0};
    wd  <= {24'h0, dt};
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    fork
      begin
        do @(posedge clk); while (awr !== 1'b1);
        awv <= 1'b0;
      end
      begin
        do @(posedge clk); while (wrd !== 1'b1);
        wv <= 1'b0;
      end
    join
    do @(posedge clk); while (bv !== 1'b1);
    bry <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, br});
  endtask

  task automatic rdm(input logic [9:0] i, input logic [31:0] m, e,
                     input logic [1:0] er);
    @(posedge clk);
    ara <= {i, 2'h0};
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rry <= 1'b0;
    chk("rdata", e, rd & m);
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask

  // Bounded wait for a DAC code, then compare
  task automatic wdac(input logic [9:0] x);
    int n;
    n = 0;
    while (dac !== x && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    chk("dac", {22'h0, x}, {22'h0, dac});
  endtask

  // Third step interval: the first may straddle a rate change
  task automatic per_chk(input int e);
    int n;
    logic [9:0] p;
    repeat (2)
    begin
      p = dac;
      while (dac === p) @(posedge clk);
    end
    p = dac;
    n = 0;
    while (dac === p)
    begin
      @(posedge clk);
      n++;
    end
    chk("period", e, n);
  endtask

  task automatic test_done();
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 32'h00008E21;
    {rst, tick, gap2} = 3'h5;
    {awv, wv, bry, arv, rry, lock} = 6'h00;
    {awa, ara, wd} = 56'h0;
    tune = 10'h3FF;
    {nsw, error_cnt, checks_done} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdm(IDX_HOLD_CTRL, 32'hFFFFFFFF, 32'h16, RESP_OKAY);
    rdm(IDX_MAN_LO, 32'hFFFFFFFF, 32'h00, RESP_OKAY);
    rdm(IDX_TRIP_LO, 32'hFFFFFFFF, 32'h00, RESP_OKAY);
    rdm(IDX_RATE_TRIP, 32'hFFFFFFFF, 32'h00, RESP_OKAY);
    rdm(IDX_RATE_CNT, 32'hFFFFFFFF, 32'h7F, RESP_OKAY);
    rdm(10'h100, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    wr(IDX_STATUS, 8'hFF, RESP_SLVERR);
    chk("dac", 32'h200, {22'h0, dac});
    for (int k = 0; k < 6; k++)
    begin
      r = rnd();
      v = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : r[9:0];
      wr(IDX_HOLD_CTRL, {6'h05, v[9:8]}, RESP_OKAY);
      wr(IDX_MAN_LO, v[7:0], RESP_OKAY);
      @(posedge clk);
      chk("dac", {22'h0, v}, {22'h0, dac});
      rdm(IDX_MAN_LO, 32'hFFFFFFFF, {24'h0, v[7:0]}, RESP_OKAY);
    end
    mlo = v[7:0];
    wr(IDX_RATE_CNT, 8'h01, RESP_OKAY);
    wr(IDX_HOLD_CTRL, 8'h10, RESP_OKAY);
    wdac(10'h200);
    lock <= 1'b1;
    wdac(10'h201);
    for (int m = 0; m < 4; m++)
    begin
      r = rnd();
      c = (m < 2) ? 8'(1 + r % 3) : 8'h01;
      gap2 <= (m < 2);
      wr(IDX_RATE_TRIP, {2'(m), 6'h00}, RESP_OKAY);
      wr(IDX_RATE_CNT, c, RESP_OKAY);
      per_chk(per_of(m, int'(c), (m < 2) ? 2 : 1));
    end
    gap2 <= 1'b1;
    wr(IDX_RATE_TRIP, 8'h00, RESP_OKAY);
    wr(IDX_RATE_CNT, 8'h01, RESP_OKAY);
    lock <= 1'b0;
    repeat (3) @(posedge clk);
    d = dac;
    repeat (100) @(posedge clk);
    chk("dac", {22'h0, d}, {22'h0, dac});
    rdm(IDX_STATUS, 32'h400, 32'h0, RESP_OKAY);
    lock <= 1'b1;
    wr(IDX_HOLD_CTRL, 8'h18, RESP_OKAY);
    repeat (3) @(posedge clk);
    d = dac;
    repeat (60) @(posedge clk);
    chk("dac", {22'h0, d}, {22'h0, dac});
    chk("hold", 32'h1, {31'h0, hold});
    wr(IDX_HOLD_CTRL, 8'h1E, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("dac", {22'h0, 2'h2, mlo}, {22'h0, dac});
    wr(IDX_HOLD_CTRL, 8'h10, RESP_OKAY);
    wdac(10'h3FF);
    repeat (40) @(posedge clk);
    chk("dac", 32'h3FF, {22'h0, dac});
    chk("switches", 32'h0, 32'(nsw));
    chk("hold", 32'h0, {31'h0, hold});
    r = rnd();
    lo = 6'(40 + r % 16);
    wr(IDX_TRIP_LO, {2'h0, lo}, RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'h03, RESP_OKAY);
    tune <= 10'h000;
    wdac(10'h3EF);
    wr(IDX_RAIL_CTRL, 8'h01, RESP_OKAY);
    wdac(lo_lvl(lo));
    repeat (3) @(posedge clk);
    chk("switches", 32'h1, 32'(nsw));
    chk("trip dac", {22'h0, lo_lvl(lo)}, {22'h0, sw_dac});
    chk("hold", 32'h1, {31'h0, hold});
    chk("irq", 32'h1, {31'h0, irq});
    rdm(IDX_IRQ_STAT, 32'hFFFFFFFF, 32'h1, RESP_OKAY);
    wr(IDX_IRQ_STAT, 8'h01, RESP_OKAY);
    rdm(IDX_IRQ_STAT, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    r = rnd();
    hi = 6'(r % 4);
    wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
    wr(IDX_RATE_TRIP, {2'h0, hi}, RESP_OKAY);
    tune <= 10'h3FF;
    wdac(hi_lvl(hi));
    repeat (3) @(posedge clk);
    chk("switches", 32'h2, 32'(nsw));
    chk("trip dac", {22'h0, hi_lvl(hi)}, {22'h0, sw_dac});
    chk("irq", 32'h0, {31'h0, irq});
    rdm(IDX_IRQ_STAT, 32'hFFFFFFFF, 32'h2, RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'h02, RESP_OKAY);
    @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_STAT, 8'h02, RESP_OKAY);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    // Zero rate count must stop tracking even with the tune code far away
    tune <= 10'h000;
    wr(IDX_RATE_CNT, 8'h00, RESP_OKAY);
    repeat (3) @(posedge clk);
    d = dac;
    repeat (100) @(posedge clk);
    chk("dac", {22'h0, d}, {22'h0, dac});
    test_done();
  end

endmodule
`default_nettype wire
